// *** inc/flash_cmd_pkg.sv ***
// constants, command codes, states and carrier types of the flash command sequencer
// Functional notes
// - d-flash verify needs index 010 at launch
// - d-flash verify rejects odd word address
// - d-flash verify start inside eeprom partition errors
// - d-flash verify section past block end errors
// - command disabled in current mode errors
// - invalid 23-bit global address errors
// - verify errors: any sets bit1, uncorrectable bit0
// - block verify: index 000, no load field, valid block
// - program d-flash code 0x11, params at 000..101
// - launch index sets one to four words
// - program d-flash: access checks, no protection checks
// - clearing complete flag launches, set when finished
// - programmed d-flash words read back and checked
// - p-flash erase verify code 0x03, count at 010
// - erase verify checks every section location erased
// - program p-flash code 0x06, four words at 010..101
// - p-flash phrase address low bits must be 000
// - programmed p-flash phrase read back then completes
package flash_cmd_pkg;
    localparam int WORD_W = 16;
    localparam int GADDR_W = 23;
    localparam int REG_ADDR_W = 4;

    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_INDEX = 4'h1;
    localparam logic [3:0] OFS_PARAM = 4'h2;
    localparam logic [3:0] OFS_CONTROL = 4'h3;
    localparam logic [3:0] OFS_EEE_BOUNDARY = 4'h4;

    localparam int ST_COMMAND_COMPLETE_FLAG = 7;
    localparam int ST_ACCESS_ERROR_FLAG = 5;
    localparam int ST_VERR_ANY = 1;
    localparam int ST_VERR_UNC = 0;
    localparam int CTRL_LOAD_FIELD = 5;

    localparam int CEN_PROG_D = 0;
    localparam int CEN_VER_D = 1;
    localparam int CEN_VER_P = 2;
    localparam int CEN_PROG_P = 3;
    localparam int CEN_VER_BLK = 4;
    localparam logic [4:0] CEN_RESET = 5'h1f;

    localparam logic [7:0] CMD_PROG_D = 8'h11;
    localparam logic [7:0] CMD_VER_D = 8'h10;
    localparam logic [7:0] CMD_VER_P = 8'h03;
    localparam logic [7:0] CMD_PROG_P = 8'h06;
    localparam logic [7:0] CMD_VER_BLK = 8'h02;

    localparam logic [2:0] IDX_BLOCK = 3'h0;
    localparam logic [2:0] IDX_ADDR = 3'h1;
    localparam logic [2:0] IDX_DATA0 = 3'h2;
    localparam logic [2:0] IDX_LAST = 3'h5;
    localparam int NUM_PARAMS = 6;

    localparam logic [6:0] DFLASH_BLOCK_ID = 7'h10;
    localparam logic [6:0] PFLASH_BLOCK_LO = 7'h40;
    localparam logic [15:0] DFLASH_SIZE = 16'h8000;
    localparam logic [17:0] PFLASH_BLOCK_WORDS = 18'h0_8000;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CHECK = 5'b00010,
        ST_PROG = 5'b00100,
        ST_READ = 5'b01000,
        ST_CMP = 5'b10000
    } seq_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [REG_ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [GADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } mem_req_type;

    typedef struct packed {
        logic [WORD_W-1:0] rdata;
        logic err_any;
        logic err_uncorr;
    } mem_rsp_type;
endpackage : flash_cmd_pkg

// *** hw/flash_cmd_sequencer.sv ***
// flash command sequencer: parameter registers, launch checks, program and verify
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_sequencer (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire flash_cmd_pkg::reg_req_type reg_req,
    output logic [15:0] reg_rdata,
    output var flash_cmd_pkg::mem_req_type mem_req,
    input wire flash_cmd_pkg::mem_rsp_type mem_rsp
);
    flash_cmd_pkg::seq_state_type state_reg;
    logic [15:0] param_reg [0:flash_cmd_pkg::NUM_PARAMS-1];
    logic [2:0] index_reg;
    logic [2:0] launch_index_reg;
    logic command_complete_flag_reg;
    logic access_error_flag_reg;
    logic verr_any_reg;
    logic verr_unc_reg;
    logic [4:0] cmd_enable_reg;
    logic load_field_reg;
    logic [15:0] eee_boundary_reg;
    logic [22:0] addr_reg;
    logic [22:0] base_reg;
    logic [17:0] remain_reg;
    logic [17:0] total_reg;
    logic [2:0] word_idx_reg;
    logic [15:0] wdata_reg;
    logic is_prog_reg;
    logic [15:0] rdata_reg;

    logic launch;
    logic clr_access_error_flag;
    logic finish;
    logic chk_err;
    logic chk_prog;
    logic [17:0] words;
    logic [22:0] start_addr;
    logic [7:0] cmd;
    logic [6:0] blk;
    logic [15:0] ofs;
    logic is_d;
    logic is_p;
    logic in_eee;
    logic breach;
    logic [17:0] end_ofs;
    logic [15:0] expect_word;
    logic mismatch;

    assign cmd = param_reg[flash_cmd_pkg::IDX_BLOCK][15:8];
    assign blk = param_reg[flash_cmd_pkg::IDX_BLOCK][6:0];
    assign ofs = param_reg[flash_cmd_pkg::IDX_ADDR];
    assign is_d = (blk == flash_cmd_pkg::DFLASH_BLOCK_ID) && (ofs < flash_cmd_pkg::DFLASH_SIZE);
    assign is_p = blk >= flash_cmd_pkg::PFLASH_BLOCK_LO;
    assign in_eee = ofs >= eee_boundary_reg;
    assign end_ofs = {2'b00, ofs} + {1'b0, param_reg[flash_cmd_pkg::IDX_DATA0], 1'b0};
    assign breach = end_ofs > {2'b00, eee_boundary_reg};

    assign launch = reg_req.wr && (reg_req.addr == flash_cmd_pkg::OFS_STATUS)
        && reg_req.wdata[flash_cmd_pkg::ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_reg
        && (state_reg == flash_cmd_pkg::ST_IDLE);
    assign clr_access_error_flag = reg_req.wr && (reg_req.addr == flash_cmd_pkg::OFS_STATUS)
        && reg_req.wdata[flash_cmd_pkg::ST_ACCESS_ERROR_FLAG];

    // launch checks; only access checks are made, nothing here looks at protection
    always_comb begin
        chk_err = 1'b0;
        chk_prog = 1'b0;
        words = 18'h0_0000;
        start_addr = {blk, ofs};
        case (cmd)
            flash_cmd_pkg::CMD_PROG_D: begin
                chk_err = !cmd_enable_reg[flash_cmd_pkg::CEN_PROG_D]
                    || (launch_index_reg < flash_cmd_pkg::IDX_DATA0)
                    || (launch_index_reg > flash_cmd_pkg::IDX_LAST)
                    || !is_d || ofs[0] || in_eee;
                chk_prog = 1'b1;
                words = {15'h0000, launch_index_reg - 3'h1};
            end
            flash_cmd_pkg::CMD_VER_D: begin
                chk_err = !cmd_enable_reg[flash_cmd_pkg::CEN_VER_D]
                    || (launch_index_reg != flash_cmd_pkg::IDX_DATA0)
                    || !is_d
                    || ofs[0]
                    || in_eee
                    || breach
                    || (param_reg[flash_cmd_pkg::IDX_DATA0] == 16'h0000);
                words = {2'b00, param_reg[flash_cmd_pkg::IDX_DATA0]};
            end
            flash_cmd_pkg::CMD_VER_P: begin
                chk_err = !cmd_enable_reg[flash_cmd_pkg::CEN_VER_P]
                    || (launch_index_reg != flash_cmd_pkg::IDX_DATA0)
                    || !is_p || (ofs[2:0] != 3'h0)
                    || (param_reg[flash_cmd_pkg::IDX_DATA0] == 16'h0000);
                words = {param_reg[flash_cmd_pkg::IDX_DATA0], 2'b00};
            end
            flash_cmd_pkg::CMD_PROG_P: begin
                chk_err = !cmd_enable_reg[flash_cmd_pkg::CEN_PROG_P]
                    || (launch_index_reg != flash_cmd_pkg::IDX_LAST)
                    || !is_p
                    || (ofs[2:0] != 3'h0)
                    || load_field_reg;
                chk_prog = 1'b1;
                words = 18'h0_0004;
            end
            flash_cmd_pkg::CMD_VER_BLK: begin
                chk_err = !cmd_enable_reg[flash_cmd_pkg::CEN_VER_BLK]
                    || (launch_index_reg != flash_cmd_pkg::IDX_BLOCK)
                    || load_field_reg
                    || !((blk == flash_cmd_pkg::DFLASH_BLOCK_ID) || is_p);
                start_addr = {blk, 16'h0000};
                words = is_p ? flash_cmd_pkg::PFLASH_BLOCK_WORDS
                    : {3'b000, eee_boundary_reg[15:1]};
            end
            default: chk_err = 1'b1;
        endcase
    end

    assign expect_word = is_prog_reg
        ? param_reg[3'(word_idx_reg + flash_cmd_pkg::IDX_DATA0)] : flash_cmd_pkg::ERASED_WORD;
    assign mismatch = mem_rsp.rdata != expect_word;
    // an empty block verify ends straight from the check
    assign finish = ((state_reg == flash_cmd_pkg::ST_CHECK) && (chk_err || words == 18'h0_0000))
        || ((state_reg == flash_cmd_pkg::ST_CMP) && (remain_reg == 18'h0_0001));

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg <= flash_cmd_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                flash_cmd_pkg::ST_IDLE: if (launch) state_reg <= flash_cmd_pkg::ST_CHECK;
                flash_cmd_pkg::ST_CHECK: begin
                    if (finish) begin
                        state_reg <= flash_cmd_pkg::ST_IDLE;
                    end else if (chk_prog) begin
                        state_reg <= flash_cmd_pkg::ST_PROG;
                    end else begin
                        state_reg <= flash_cmd_pkg::ST_READ;
                    end
                end
                flash_cmd_pkg::ST_PROG: begin
                    if (remain_reg == 18'h0_0001) state_reg <= flash_cmd_pkg::ST_READ;
                end
                flash_cmd_pkg::ST_READ: state_reg <= flash_cmd_pkg::ST_CMP;
                flash_cmd_pkg::ST_CMP: begin
                    state_reg <= finish ? flash_cmd_pkg::ST_IDLE : flash_cmd_pkg::ST_READ;
                end
                default: state_reg <= flash_cmd_pkg::ST_IDLE;
            endcase
        end
    end

    // status flags; a hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            command_complete_flag_reg <= 1'b1;
            access_error_flag_reg <= 1'b0;
            verr_any_reg <= 1'b0;
            verr_unc_reg <= 1'b0;
        end else begin
            command_complete_flag_reg <= finish || (command_complete_flag_reg && !launch);
            access_error_flag_reg <= ((state_reg == flash_cmd_pkg::ST_CHECK) && chk_err)
                || (access_error_flag_reg && !clr_access_error_flag);
            if (launch) begin
                verr_any_reg <= 1'b0;
                verr_unc_reg <= 1'b0;
            end else if (state_reg == flash_cmd_pkg::ST_CMP) begin
                // a wrong word cannot be corrected, so it counts as uncorrectable
                verr_any_reg <= verr_any_reg || mismatch || mem_rsp.err_any
                    || mem_rsp.err_uncorr;
                verr_unc_reg <= verr_unc_reg || mismatch || mem_rsp.err_uncorr;
            end
        end
    end

    // software registers; parameters are frozen while a command runs
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            for (int i = 0; i < flash_cmd_pkg::NUM_PARAMS; i++) begin
                param_reg[i] <= 16'h0000;
            end
            index_reg <= 3'h0;
            cmd_enable_reg <= flash_cmd_pkg::CEN_RESET;
            load_field_reg <= 1'b0;
            eee_boundary_reg <= flash_cmd_pkg::DFLASH_SIZE;
        end else if (reg_req.wr && command_complete_flag_reg) begin
            case (reg_req.addr)
                flash_cmd_pkg::OFS_INDEX: index_reg <= reg_req.wdata[2:0];
                flash_cmd_pkg::OFS_PARAM: begin
                    if (index_reg <= flash_cmd_pkg::IDX_LAST) param_reg[index_reg] <= reg_req.wdata;
                end
                flash_cmd_pkg::OFS_CONTROL: begin
                    cmd_enable_reg <= reg_req.wdata[4:0];
                    load_field_reg <= reg_req.wdata[flash_cmd_pkg::CTRL_LOAD_FIELD];
                end
                flash_cmd_pkg::OFS_EEE_BOUNDARY: begin
                    eee_boundary_reg <= (reg_req.wdata > flash_cmd_pkg::DFLASH_SIZE)
                        ? flash_cmd_pkg::DFLASH_SIZE : reg_req.wdata;
                end
                default: ;
            endcase
        end
    end

    // address walk over the program pass and then the read-back pass
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            launch_index_reg <= 3'h0;
            addr_reg <= 23'h00_0000;
            base_reg <= 23'h00_0000;
            remain_reg <= 18'h0_0000;
            total_reg <= 18'h0_0000;
            word_idx_reg <= 3'h0;
            wdata_reg <= 16'h0000;
            is_prog_reg <= 1'b0;
        end else if (launch) begin
            launch_index_reg <= index_reg;
        end else if (state_reg == flash_cmd_pkg::ST_CHECK) begin
            addr_reg <= start_addr;
            base_reg <= start_addr;
            remain_reg <= words;
            total_reg <= words;
            word_idx_reg <= 3'h0;
            wdata_reg <= param_reg[flash_cmd_pkg::IDX_DATA0];
            is_prog_reg <= chk_prog;
        end else if (state_reg == flash_cmd_pkg::ST_PROG) begin
            if (remain_reg == 18'h0_0001) begin
                addr_reg <= base_reg;
                remain_reg <= total_reg;
                word_idx_reg <= 3'h0;
            end else begin
                addr_reg <= addr_reg + 23'h00_0002;
                remain_reg <= remain_reg - 18'h0_0001;
                word_idx_reg <= word_idx_reg + 3'h1;
                wdata_reg <= param_reg[3'(word_idx_reg + 3'h3)];
            end
        end else if (state_reg == flash_cmd_pkg::ST_CMP) begin
            addr_reg <= addr_reg + 23'h00_0002;
            remain_reg <= remain_reg - 18'h0_0001;
            word_idx_reg <= word_idx_reg + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata_reg <= 16'h0000;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                flash_cmd_pkg::OFS_STATUS: rdata_reg <= {8'h00, command_complete_flag_reg, 1'b0, access_error_flag_reg,
                    3'b000, verr_any_reg, verr_unc_reg};
                flash_cmd_pkg::OFS_INDEX: rdata_reg <= {13'h0000, index_reg};
                flash_cmd_pkg::OFS_PARAM: rdata_reg <= (index_reg <= flash_cmd_pkg::IDX_LAST)
                    ? param_reg[index_reg] : 16'h0000;
                flash_cmd_pkg::OFS_CONTROL: rdata_reg <= {10'h000, load_field_reg, cmd_enable_reg};
                flash_cmd_pkg::OFS_EEE_BOUNDARY: rdata_reg <= eee_boundary_reg;
                default: rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_reg;
    assign mem_req.wr = state_reg == flash_cmd_pkg::ST_PROG;
    assign mem_req.rd = state_reg == flash_cmd_pkg::ST_READ;
    assign mem_req.addr = addr_reg;
    assign mem_req.wdata = wdata_reg;

    // helper: flash writes since launch
    logic [2:0] writes_seen;
    always_ff @(posedge clk_sys) begin
        if (!rst_b || launch) begin
            writes_seen <= 3'h0;
        end else if (mem_req.wr) begin
            writes_seen <= writes_seen + 3'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_check(logic [7:0] c);
        state_reg == flash_cmd_pkg::ST_CHECK && cmd == c;
    endsequence
    sequence s_rejected;
        state_reg == flash_cmd_pkg::ST_IDLE && command_complete_flag_reg && access_error_flag_reg;
    endsequence

    property p_launch;
        launch |=> !command_complete_flag_reg && state_reg == flash_cmd_pkg::ST_CHECK;
    endproperty
    a_launch: assert property (p_launch) else $error("launch did not start");
    property p_reject;
        state_reg == flash_cmd_pkg::ST_CHECK && chk_err |=> s_rejected ##1 !mem_req.wr;
    endproperty
    a_reject: assert property (p_reject) else $error("rejected command kept going");
    property p_ver_d_index;
        s_check(flash_cmd_pkg::CMD_VER_D) ##0 launch_index_reg != 3'h2 |=> s_rejected;
    endproperty
    a_ver_d_index: assert property (p_ver_d_index) else $error("bad index accepted");
    property p_ver_d_odd;
        s_check(flash_cmd_pkg::CMD_VER_D) ##0 ofs[0] |=> s_rejected;
    endproperty
    a_ver_d_odd: assert property (p_ver_d_odd) else $error("odd address accepted");
    property p_ver_d_eee;
        s_check(flash_cmd_pkg::CMD_VER_D) ##0 (in_eee || breach) |=> s_rejected;
    endproperty
    a_ver_d_eee: assert property (p_ver_d_eee) else $error("eeprom area accepted");
    property p_mode;
        s_check(flash_cmd_pkg::CMD_PROG_D) ##0 !cmd_enable_reg[flash_cmd_pkg::CEN_PROG_D]
            |=> s_rejected;
    endproperty
    a_mode: assert property (p_mode) else $error("disabled command accepted");
    property p_align;
        s_check(flash_cmd_pkg::CMD_PROG_P) ##0 ofs[2:0] != 3'h0 |=> s_rejected;
    endproperty
    a_align: assert property (p_align) else $error("misaligned phrase accepted");
    property p_blk;
        s_check(flash_cmd_pkg::CMD_VER_BLK) ##0 load_field_reg |=> s_rejected;
    endproperty
    a_blk: assert property (p_blk) else $error("block verify accepted in load field");
    property p_count;
        state_reg == flash_cmd_pkg::ST_PROG ##1 state_reg == flash_cmd_pkg::ST_READ
            |-> writes_seen == total_reg[2:0];
    endproperty
    a_count: assert property (p_count) else $error("wrong number of words written");
    property p_readback;
        state_reg == flash_cmd_pkg::ST_PROG && remain_reg == 18'h0_0001
            |=> mem_req.rd && mem_req.addr == base_reg ##1 state_reg == flash_cmd_pkg::ST_CMP;
    endproperty
    a_readback: assert property (p_readback) else $error("no read back after program");
    property p_verr;
        state_reg == flash_cmd_pkg::ST_CMP && mem_rsp.err_uncorr
            |=> verr_any_reg && verr_unc_reg;
    endproperty
    a_verr: assert property (p_verr) else $error("uncorrectable error not reported");
    property p_erased;
        state_reg == flash_cmd_pkg::ST_CMP && !is_prog_reg && mem_rsp.rdata != 16'hffff
            |=> verr_any_reg;
    endproperty
    a_erased: assert property (p_erased) else $error("unerased word missed");
endmodule : flash_cmd_sequencer
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    flash_cmd_pkg::reg_req_type reg_req = '0;
    logic [15:0] reg_rdata;
    flash_cmd_pkg::mem_req_type mem_req;
    flash_cmd_pkg::mem_rsp_type mem_rsp = '0;
    logic note = 1'b0;
    logic rd_seen = 1'b0;
    logic [15:0] flip = '0;
    logic inj_any = 1'b0;
    logic inj_unc = 1'b0;
    logic [15:0] mem [logic [22:0]];
    logic [15:0] wd [4];
    logic [15:0] er_q [$];
    string nm_q [$];
    logic [38:0] ew_q [$];
    logic [22:0] ra_q [$];
    int miscompares = 0;
    int num_checks = 0;

    flash_cmd_sequencer flash_cmd_sequencer_i (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .mem_req(mem_req),
        .mem_rsp(mem_rsp)
    );

    always #25 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [38:0] exp, input logic [38:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %0s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // a flash access that no scenario announced
    task automatic extra(input string what, input logic [38:0] got);
        num_checks++;
        miscompares++;
        $display("wrong value %0s expected none seen %h", what, got);
    endtask : extra

    task automatic summarize();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // flash array answers one cycle after a read; between reads the lines toggle
    always @(posedge clk_sys) begin
        rd_seen <= reg_req.rd & note;
        if (mem_req.wr === 1'b1) mem[mem_req.addr] = mem_req.wdata;
        if (mem_req.rd === 1'b1) begin
            mem_rsp <= '{(mem.exists(mem_req.addr) ? mem[mem_req.addr]
                          : flash_cmd_pkg::ERASED_WORD) ^ flip, inj_any, inj_unc};
        end else begin
            mem_rsp <= flash_cmd_pkg::mem_rsp_type'(~mem_rsp);
        end
    end

    always @(negedge clk_sys) begin
        if (rd_seen) check(nm_q.pop_front(), 39'(er_q.pop_front()), 39'(reg_rdata));
        if (mem_req.wr === 1'b1) begin
            if (ew_q.size() == 0) extra("flash write", {mem_req.addr, mem_req.wdata});
            else check("flash write", ew_q.pop_front(), {mem_req.addr, mem_req.wdata});
        end
        if (mem_req.rd === 1'b1) begin
            if (ra_q.size() == 0) extra("flash read", 39'(mem_req.addr));
            else check("flash read address", 39'(ra_q.pop_front()), 39'(mem_req.addr));
        end
    end

    task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d,
                       input logic n);
        @(posedge clk_sys);
        reg_req <= '{w, r, a, d};
        note <= n;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d, 1'b0);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
        er_q.push_back(exp);
        nm_q.push_back(what);
        bus(1'b0, 1'b1, a, 16'h0000, 1'b1);
        bus(1'b0, 1'b0, 4'h0, 16'h0000, 1'b0);
    endtask : rd_chk

    task automatic poll();
        logic [15:0] v;
        int i;
        v = '0;
        for (i = 0; i < 3000 && v[7] !== 1'b1; i++) begin
            bus(1'b0, 1'b1, flash_cmd_pkg::OFS_STATUS, 16'h0000, 1'b0);
            bus(1'b0, 1'b0, 4'h0, 16'h0000, 1'b0);
            @(negedge clk_sys);
            v = reg_rdata;
        end
        if (v[7] !== 1'b1) begin
            miscompares++;
            $display("wrong value command_complete_flag expected 1 seen %b", v[7]);
            summarize();
        end
    endtask : poll

    task automatic exp_r(input logic [22:0] base, input int n);
        int i;
        for (i = 0; i < n; i++) ra_q.push_back(base + 23'(2 * i));
    endtask : exp_r

    // programmed words are read back from the same addresses
    task automatic exp_w(input logic [22:0] base, input int n);
        int i;
        exp_r(base, n);
        for (i = 0; i < n; i++) ew_q.push_back({base + 23'(2 * i), wd[i]});
    endtask : exp_w

    // loads parameters up to idx, launches, waits for completion, checks status
    task automatic run(input string name, input logic [7:0] c, input logic [6:0] blk,
                       input logic [15:0] a, input logic [2:0] idx, input logic [15:0] ctrl,
                       input logic [15:0] eee, input logic [15:0] exp);
        int i;
        wr(flash_cmd_pkg::OFS_CONTROL, ctrl);
        wr(flash_cmd_pkg::OFS_EEE_BOUNDARY, eee);
        wr(flash_cmd_pkg::OFS_STATUS, 16'h0020);
        for (i = 0; i <= idx; i++) begin
            wr(flash_cmd_pkg::OFS_INDEX, 16'(i));
            wr(flash_cmd_pkg::OFS_PARAM, i == 0 ? {c, 1'b0, blk} : i == 1 ? a : wd[i - 2]);
        end
        wr(flash_cmd_pkg::OFS_INDEX, {13'h0, idx});
        wr(flash_cmd_pkg::OFS_STATUS, 16'h0080);
        // command_complete_flag only drops one cycle after the launch edge
        repeat (3) bus(1'b0, 1'b0, 4'h0, 16'h0000, 1'b0);
        poll();
        num_checks++;
        if (ew_q.size() + ra_q.size() != 0) begin
            miscompares++;
            $display("wrong value pending flash accesses expected 0 seen %0d",
                     ew_q.size() + ra_q.size());
            ew_q.delete();
            ra_q.delete();
        end
        rd_chk(flash_cmd_pkg::OFS_STATUS, exp, "status");
        $display("test %0s done", name);
    endtask : run

    initial begin
        void'($urandom(32'h7d06));
        foreach (wd[k]) wd[k] = 16'($urandom());
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd_chk(flash_cmd_pkg::OFS_STATUS, 16'h0080, "status reset");
        rd_chk(flash_cmd_pkg::OFS_CONTROL, 16'h001f, "control reset");
        rd_chk(flash_cmd_pkg::OFS_EEE_BOUNDARY, 16'h8000, "eee reset");
        rd_chk(flash_cmd_pkg::OFS_INDEX, 16'h0000, "index reset");
        wr(flash_cmd_pkg::OFS_INDEX, 16'h0003);
        wr(flash_cmd_pkg::OFS_PARAM, 16'h1234);
        rd_chk(flash_cmd_pkg::OFS_PARAM, 16'h1234, "param");
        wr(flash_cmd_pkg::OFS_INDEX, 16'h0006);
        wr(flash_cmd_pkg::OFS_PARAM, 16'h5678);
        rd_chk(flash_cmd_pkg::OFS_PARAM, 16'h0000, "param high index");
        wr(4'h9, 16'hffff);
        rd_chk(4'h9, 16'h0000, "unmapped");
        $display("test reset done");
        exp_w(23'h10_0100, 1);
        run("prog d one", 8'h11, 7'h10, 16'h0100, 3'h2, 16'h001f, 16'h8000, 16'h0080);
        exp_w(23'h10_0200, 4);
        run("prog d four", 8'h11, 7'h10, 16'h0200, 3'h5, 16'h001f, 16'h8000, 16'h0080);
        flip <= 16'h0001;
        exp_w(23'h10_0300, 1);
        run("prog d mismatch", 8'h11, 7'h10, 16'h0300, 3'h2, 16'h001f, 16'h8000, 16'h0083);
        flip <= 16'h0000;
        inj_any <= 1'b1;
        wd[0] = 16'h0001;
        exp_r(23'h41_0100, 4);
        run("blank p any", 8'h03, 7'h41, 16'h0100, 3'h2, 16'h001f, 16'h8000, 16'h0082);
        inj_unc <= 1'b1;
        exp_r(23'h41_0100, 4);
        run("blank p unc", 8'h03, 7'h41, 16'h0100, 3'h2, 16'h001f, 16'h8000, 16'h0083);
        inj_any <= 1'b0;
        inj_unc <= 1'b0;
        exp_r(23'h41_0100, 4);
        run("blank p", 8'h03, 7'h41, 16'h0100, 3'h2, 16'h001f, 16'h8000, 16'h0080);
        foreach (wd[k]) wd[k] = 16'($urandom());
        exp_w(23'h40_0010, 4);
        run("prog p", 8'h06, 7'h40, 16'h0010, 3'h5, 16'h001f, 16'h8000, 16'h0080);
        run("prog p odd", 8'h06, 7'h40, 16'h0012, 3'h5, 16'h001f, 16'h8000, 16'h00a0);
        // the phrase just programmed is no longer erased
        wd[0] = 16'h0001;
        exp_r(23'h40_0010, 4);
        run("blank p dirty", 8'h03, 7'h40, 16'h0010, 3'h2, 16'h001f, 16'h8000, 16'h0083);
        run("prog d mode", 8'h11, 7'h10, 16'h0500, 3'h2, 16'h001e, 16'h8000, 16'h00a0);
        wd[0] = 16'h0002;
        exp_r(23'h10_0400, 2);
        run("verify d", 8'h10, 7'h10, 16'h0400, 3'h2, 16'h001f, 16'h8000, 16'h0080);
        run("verify d idx", 8'h10, 7'h10, 16'h0400, 3'h3, 16'h001f, 16'h8000, 16'h00a0);
        run("verify d odd", 8'h10, 7'h10, 16'h0401, 3'h2, 16'h001f, 16'h8000, 16'h00a0);
        run("verify d eee", 8'h10, 7'h10, 16'h4000, 3'h2, 16'h001f, 16'h4000, 16'h00a0);
        run("verify d end", 8'h10, 7'h10, 16'h7ffe, 3'h2, 16'h001f, 16'h8000, 16'h00a0);
        run("verify d mode", 8'h10, 7'h10, 16'h0400, 3'h2, 16'h001d, 16'h8000, 16'h00a0);
        run("verify d block", 8'h10, 7'h20, 16'h0400, 3'h2, 16'h001f, 16'h8000, 16'h00a0);
        run("blk verify index", 8'h02, 7'h10, 16'h0000, 3'h1, 16'h001f, 16'h8000, 16'h00a0);
        run("blk verify load", 8'h02, 7'h10, 16'h0000, 3'h0, 16'h003f, 16'h8000, 16'h00a0);
        run("blk verify block", 8'h02, 7'h20, 16'h0000, 3'h0, 16'h001f, 16'h8000, 16'h00a0);
        summarize();
    end
endmodule : tb
`default_nettype wire
